// >>> src/fan_mon_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the fan tach
 period monitor. Assumes a 20 MHz reference clock and a byte-addressed register bus.
*/
`ifndef FAN_MON_MAP_SVH
`define FAN_MON_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_LIMIT 5'h00
`define OFS_READING 5'h04
`define OFS_CSR 5'h08
`define OFS_MASK 5'h0c

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CSR_SEL_HI 6
`define CSR_SEL_LO 5
`define CSR_BYP 4
`define CSR_IE 3
`define CSR_OVF 2
`define CSR_OVTH 1
`define CSR_RDY 0
`define LIMIT_RST 8'hff
`define READING_RST 8'h00
`define SEL_RST 2'h1
`define MASK_RST 2'h3
`define COUNT_MAX 8'hff

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define RATE16_PERIOD_NS 62500
`define RATE16_CYCLES (`RATE16_PERIOD_NS / `CLK_PERIOD_NS)
`define FILT_PERIOD_NS 31250
`define FILT_CYCLES (`FILT_PERIOD_NS / `CLK_PERIOD_NS)
`define FILT_MIN_NS 750000
`define FILT_TICKS ((`FILT_MIN_NS + `FILT_PERIOD_NS - 1) / `FILT_PERIOD_NS)

`endif

// >>> src/fan_mon_pkg.sv
/*
 Types shared by the fan tach period monitor and its input filter.
 Assumes the constants of fan_mon_map.svh.
*/
package fan_mon_pkg;

    // ------------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        PH_WAIT = 1'b0,
        PH_MEAS = 1'b1
    } phase_t;

    typedef enum logic [2:0] {
        SEL_LIMIT = 3'b000,
        SEL_READING = 3'b001,
        SEL_CSR = 3'b010,
        SEL_MASK = 3'b011,
        SEL_NONE = 3'b100
    } reg_sel_t;

    // ------------------------------------------------------------------------
    // State records
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] limit;
        logic [7:0] reading;
        logic [7:0] cnt;
        logic ovf;
        logic ovth;
        logic rdy;
        logic hold;
        logic [1:0] sel;
        logic byp;
        logic ie;
        logic [1:0] mask;
        phase_t phase;
        logic [15:0] pre;
        logic [2:0] div;
        logic ack;
        logic [7:0] rdata;
    } mon_state_t;

    typedef struct packed {
        logic [15:0] pre;
        logic [7:0] run;
        logic filt;
        logic lvl;
        logic rise;
    } filt_state_t;

endpackage

// >>> src/tach_if.sv
/*
 Carrier between the monitor and its tach input filter.
 Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface tach_if;
    logic raw;
    logic bypass;
    logic rise;
    modport filt (input raw, input bypass, output rise);
    modport mon (output raw, output bypass, input rise);
endinterface
`default_nettype wire

// >>> src/tach_glitch_filter.sv
/*
 Tach input glitch filter with bypass and rising edge detection.
 Assumes the raw tach input is already synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fan_mon_map.svh"
module tach_glitch_filter #(
    parameter int FILT_DIV = `FILT_CYCLES,
    parameter int FILT_N = `FILT_TICKS
) (
    input wire logic ref_clk,
    input wire logic rst,
    tach_if.filt tach
);
    import fan_mon_pkg::*;

    filt_state_t st_q;
    filt_state_t st_d;
    logic tick;

    // ------------------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------------------
    assign tick = (st_q.pre == 16'(FILT_DIV - 1));

    always_comb begin
        st_d = st_q;
        st_d.pre = tick ? 16'h0000 : st_q.pre + 16'h0001;
        // A level must hold through FILT_N consecutive filter ticks before it is adopted.
        if (tach.raw == st_q.filt) begin
            st_d.run = 8'h00;
        end else if (tick) begin
            if (st_q.run == 8'(FILT_N - 1)) begin
                st_d.filt = tach.raw;
                st_d.run = 8'h00;
            end else begin
                st_d.run = st_q.run + 8'h01;
            end
        end
        st_d.lvl = tach.bypass ? tach.raw : st_d.filt;
        st_d.rise = st_d.lvl & ~st_q.lvl;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tach.rise = st_q.rise;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_filt_adopt;
        @(posedge ref_clk) disable iff (rst)
        (st_q.filt != $past(st_q.filt)) |-> $past(tick) && ($past(st_q.run) == 8'(FILT_N - 1));
    endproperty
    a_filt_adopt: assert property (p_filt_adopt) else $error("filter took a short pulse");

    property p_bypass_edge;
        @(posedge ref_clk) disable iff (rst)
        (tach.bypass && $rose(tach.raw) && $past(tach.bypass)) |=> tach.rise;
    endproperty
    a_bypass_edge: assert property (p_bypass_edge) else $error("bypassed edge not seen");
endmodule
`default_nettype wire

// >>> src/fan_tach_period_monitor.sv
/*
 Fan tach period monitor: counts selected-rate ticks between tach rising edges,
 captures the count, compares it with a limit and raises an interrupt.
 Assumes an Avalon-MM master with waitrequest and a synchronous tach input.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fan_mon_map.svh"
module fan_tach_period_monitor #(
    parameter int RATE_DIV = `RATE16_CYCLES,
    parameter int FILT_DIV = `FILT_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic monitor_en,
    input wire logic tach_pulse_in,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    output fan_mon_pkg::phase_t meas_phase
);
    import fan_mon_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic reg_sel_t decode(input logic [4:0] addr);
        reg_sel_t sel;
        if (addr == `OFS_LIMIT) begin
            sel = SEL_LIMIT;
        end else if (addr == `OFS_READING) begin
            sel = SEL_READING;
        end else if (addr == `OFS_CSR) begin
            sel = SEL_CSR;
        end else if (addr == `OFS_MASK) begin
            sel = SEL_MASK;
        end else begin
            sel = SEL_NONE;
        end
        return sel;
    endfunction

    function automatic logic [2:0] rate_mask(input logic [1:0] sel);
        logic [2:0] m;
        case (sel)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            default: m = 3'h7;
        endcase
        return m;
    endfunction

    mon_state_t st_q;
    mon_state_t st_d;
    tach_if tach ();

    logic acc;
    logic take_wr;
    logic take_rd;
    logic wr_lo;
    reg_sel_t sel_now;
    logic counting;
    logic rate_tick;
    logic edge_in;
    logic blocked;
    logic cap_now;
    logic [7:0] csr_view;

    // ------------------------------------------------------------------------
    // Tach input
    // ------------------------------------------------------------------------
    assign tach.raw = tach_pulse_in;
    assign tach.bypass = st_q.byp;

    tach_glitch_filter #(
        .FILT_DIV(FILT_DIV),
        .FILT_N(`FILT_TICKS)
    ) u_filter (
        .ref_clk(ref_clk),
        .rst(rst),
        .tach(tach)
    );

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // Every access takes two cycles so the read side effect and the write land
    // on the same edge that the master sees waitrequest low.
    assign acc = avs_read | avs_write;
    assign avs_waitrequest = acc & ~st_q.ack;
    assign sel_now = decode(avs_address);
    assign take_wr = avs_write & st_q.ack;
    assign take_rd = avs_read & st_q.ack;
    assign wr_lo = take_wr & avs_byteenable[0];
    assign csr_view = {1'b0, st_q.sel, st_q.byp, st_q.ie, st_q.ovf, st_q.ovth, st_q.rdy};

    // ------------------------------------------------------------------------
    // Measurement qualifiers
    // ------------------------------------------------------------------------
    assign counting = monitor_en && (st_q.phase == PH_MEAS) && !st_q.ovf;
    assign rate_tick = counting && (st_q.pre == 16'(RATE_DIV - 1))
        && ((st_q.div & rate_mask(st_q.sel)) == rate_mask(st_q.sel));
    assign edge_in = monitor_en && tach.rise;
    assign blocked = st_q.ovth | st_q.hold | st_q.ovf;
    assign cap_now = edge_in && (st_q.phase == PH_MEAS) && !blocked;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ack = acc & ~st_q.ack;
        if (acc && !st_q.ack) begin
            if (sel_now == SEL_LIMIT) begin
                st_d.rdata = st_q.limit;
            end else if (sel_now == SEL_READING) begin
                st_d.rdata = cap_now ? st_q.cnt : st_q.reading;
            end else if (sel_now == SEL_CSR) begin
                st_d.rdata = csr_view;
            end else if (sel_now == SEL_MASK) begin
                st_d.rdata = {5'h00, st_q.mask, 1'b0};
            end else begin
                st_d.rdata = 8'h00;
            end
        end

        // Register writes; the flag clears come first so a set below wins.
        if (wr_lo && sel_now == SEL_LIMIT) begin
            st_d.limit = avs_writedata[7:0];
        end else if (wr_lo && sel_now == SEL_CSR) begin
            st_d.sel = avs_writedata[`CSR_SEL_HI:`CSR_SEL_LO];
            st_d.byp = avs_writedata[`CSR_BYP];
            st_d.ie = avs_writedata[`CSR_IE];
            if (avs_writedata[`CSR_OVF]) begin
                st_d.ovf = 1'b0;
            end
            if (avs_writedata[`CSR_OVTH]) begin
                st_d.ovth = 1'b0;
            end
        end else if (wr_lo && sel_now == SEL_MASK) begin
            st_d.mask = avs_writedata[2:1];
        end
        if (take_rd && sel_now == SEL_READING) begin
            st_d.rdy = 1'b0;
            st_d.hold = 1'b0;
        end

        // Prescaler to the selected rate.
        if (counting) begin
            if (st_q.pre == 16'(RATE_DIV - 1)) begin
                st_d.pre = 16'h0000;
                st_d.div = st_q.div + 3'h1;
            end else begin
                st_d.pre = st_q.pre + 16'h0001;
            end
        end
        if (rate_tick) begin
            if (st_q.cnt == `COUNT_MAX) begin
                st_d.ovf = 1'b1;
                st_d.reading = `READING_RST;
                st_d.rdy = 1'b0;
                st_d.cnt = 8'h00;
                st_d.phase = PH_WAIT;
            end else begin
                st_d.cnt = st_q.cnt + 8'h01;
            end
        end

        // An edge restarts the period; it wins over a tick in the same cycle.
        if (edge_in && st_q.phase == PH_WAIT && !st_q.ovf) begin
            st_d.phase = PH_MEAS;
            st_d.cnt = 8'h00;
            st_d.pre = 16'h0000;
            st_d.div = 3'h0;
        end else if (edge_in && st_q.phase == PH_MEAS) begin
            st_d.phase = PH_MEAS;
            st_d.cnt = 8'h00;
            st_d.pre = 16'h0000;
            st_d.div = 3'h0;
            st_d.ovf = st_q.ovf && !(wr_lo && sel_now == SEL_CSR && avs_writedata[`CSR_OVF]);
            if (cap_now) begin
                st_d.reading = st_q.cnt;
                st_d.rdy = 1'b1;
                if (st_q.cnt > st_q.limit) begin
                    st_d.ovth = 1'b1;
                    st_d.hold = 1'b1;
                end
            end
        end

        if (!monitor_en) begin
            st_d.cnt = 8'h00;
            st_d.reading = `READING_RST;
            st_d.rdy = 1'b0;
            st_d.hold = 1'b0;
            st_d.phase = PH_WAIT;
            st_d.pre = 16'h0000;
            st_d.div = 3'h0;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.limit <= `LIMIT_RST;
            st_q.sel <= `SEL_RST;
            st_q.mask <= `MASK_RST;
            st_q.phase <= PH_WAIT;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign avs_readdata = {24'h000000, st_q.rdata};
    assign irq = st_q.ie
        && ((st_q.ovf && st_q.mask[1]) || (st_q.ovth && st_q.mask[0]));
    assign meas_phase = st_q.phase;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_capture_over;
        cap_now && (st_q.cnt > st_q.limit);
    endsequence

    sequence s_read_speed;
        take_rd && (sel_now == SEL_READING) && !cap_now;
    endsequence

    property p_limit_reset;
        @(posedge ref_clk) $fell(rst) |-> (st_q.limit == `LIMIT_RST);
    endproperty
    a_limit_reset: assert property (p_limit_reset) else $error("limit not all ones");

    property p_over_irq;
        @(posedge ref_clk) disable iff (rst)
        s_capture_over ##0 (st_q.ie && st_q.mask[0]) |=> st_q.ovth ##0 irq;
    endproperty
    a_over_irq: assert property (p_over_irq) else $error("over limit gave no irq");

    property p_ovf_irq;
        @(posedge ref_clk) disable iff (rst)
        (st_q.ovf && st_q.ie && st_q.mask[1]) |-> irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

    property p_irq_off;
        @(posedge ref_clk) disable iff (rst)
        !st_q.ie |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

    property p_disabled_zero;
        @(posedge ref_clk) disable iff (rst)
        !monitor_en |=> (st_q.reading == 8'h00) && (st_q.cnt == 8'h00);
    endproperty
    a_disabled_zero: assert property (p_disabled_zero) else $error("not zero when off");

    property p_overflow;
        @(posedge ref_clk) disable iff (rst)
        (rate_tick && st_q.cnt == `COUNT_MAX && !edge_in && monitor_en)
            |=> st_q.ovf && (st_q.reading == 8'h00) && !st_q.rdy;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not handled");

    property p_read_clears;
        @(posedge ref_clk) disable iff (rst)
        s_read_speed |=> !st_q.rdy;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("ready kept after read");

    property p_hold_reading;
        @(posedge ref_clk) disable iff (rst)
        (st_q.ovth && monitor_en && st_d.ovf == st_q.ovf) |=> $stable(st_q.reading);
    endproperty
    a_hold_reading: assert property (p_hold_reading) else $error("reading moved");

    property p_first_edge;
        @(posedge ref_clk) disable iff (rst)
        (edge_in && st_q.phase == PH_WAIT && !st_q.ovf)
            |=> (st_q.phase == PH_MEAS) && $stable(st_q.reading) && (st_q.cnt == 8'h00);
    endproperty
    a_first_edge: assert property (p_first_edge) else $error("first edge captured");

    property p_count_up;
        @(posedge ref_clk) disable iff (rst)
        (rate_tick && !edge_in && st_q.cnt != `COUNT_MAX)
            |=> st_q.cnt == $past(st_q.cnt) + 8'h01;
    endproperty
    a_count_up: assert property (p_count_up) else $error("count did not step");

    property p_capture;
        @(posedge ref_clk) disable iff (rst)
        cap_now |=> (st_q.reading == $past(st_q.cnt)) && st_q.rdy && (st_q.cnt == 8'h00);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong");

    property p_wait_one;
        @(posedge ref_clk) disable iff (rst)
        (acc && !st_q.ack) |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

    property p_ovth_clear;
        @(posedge ref_clk) disable iff (rst)
        (wr_lo && sel_now == SEL_CSR && avs_writedata[`CSR_OVTH] && !cap_now)
            |=> !st_q.ovth;
    endproperty
    a_ovth_clear: assert property (p_ovth_clear) else $error("over limit not cleared");

    property p_ovf_clear;
        @(posedge ref_clk) disable iff (rst)
        (wr_lo && sel_now == SEL_CSR && avs_writedata[`CSR_OVF] && !rate_tick)
            |=> !st_q.ovf;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");

    property p_ovf_sticky;
        @(posedge ref_clk) disable iff (rst)
        (st_q.ovf && !(wr_lo && sel_now == SEL_CSR && avs_writedata[`CSR_OVF]))
            |=> st_q.ovf;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");

    property p_ovth_sticky;
        @(posedge ref_clk) disable iff (rst)
        (st_q.ovth && !(wr_lo && sel_now == SEL_CSR && avs_writedata[`CSR_OVTH]))
            |=> st_q.ovth;
    endproperty
    a_ovth_sticky: assert property (p_ovth_sticky) else $error("over limit lost");

    property p_csr_reset;
        @(posedge ref_clk) $fell(rst) |-> (st_q.sel == `SEL_RST) && !st_q.byp && !st_q.ie;
    endproperty
    a_csr_reset: assert property (p_csr_reset) else $error("control reset wrong");
endmodule
`default_nettype wire

// >>> bench/tach_source_model.sv
/*
 Behavioural fan tachometer: drives tach_pulse_in with pulses of a chosen width and period.
 Assumes the caller enters its task at a rising edge of ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tach_source_model (
    input wire logic ref_clk,
    output logic tach_pulse_in
);
    // ------------------------------------------------------------------------
    // Pulse generation
    // ------------------------------------------------------------------------
    initial begin
        tach_pulse_in = 1'b0;
    end

    // Rising edges of consecutive calls lie exactly per cycles apart.
    task automatic pulse(input int hi, input int per);
        @(posedge ref_clk);
        tach_pulse_in <= 1'b1;
        repeat (hi) @(posedge ref_clk);
        tach_pulse_in <= 1'b0;
        repeat (per - hi - 1) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// >>> bench/fan_tach_period_monitor_tb.sv
/*
 Self-checking bench for the fan tach period monitor: register access, rates, threshold,
 overflow, disable and filter. Assumes the design files and tach_source_model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fan_mon_map.svh"
module fan_tach_period_monitor_tb;
    import fan_mon_pkg::*;

    // ------------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------------
    logic ref_clk, rst, monitor_en, tach_pulse_in, avs_read, avs_write, avs_waitrequest, irq;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    phase_t meas_phase;
    logic [7:0] v;
    int miscompares, check_count;

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Short dividers keep every count within a few thousand cycles.
    fan_tach_period_monitor #(.RATE_DIV(4), .FILT_DIV(2)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .monitor_en(monitor_en), .tach_pulse_in(tach_pulse_in),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .meas_phase(meas_phase)
    );
    tach_source_model tach_u (.ref_clk(ref_clk), .tach_pulse_in(tach_pulse_in));

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waitrequest and readdata are taken at the rising edge, before that edge's update lands.
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [7:0] r);
        int n;
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            miscompares++;
            $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
            stop_test();
        end
        r = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, 4'h1, r);
    endtask

    task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, 4'hf, r);
        check(what, r, exp);
    endtask

    // The filter prescaler runs free against tach edges, so a count may differ by a tick.
    task automatic rd_range(input string what, input logic [4:0] a, input int lo, input int hi);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, 4'hf, r);
        check(what, {7'h0, (r >= lo && r <= hi)}, 8'h01);
    endtask

    task automatic enable;
        monitor_en <= 1'b1;
        @(posedge ref_clk);
        @(posedge ref_clk);
    endtask

    task automatic disable_mon;
        monitor_en <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        monitor_en = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        miscompares = 0;
        check_count = 0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd_chk("limit", `OFS_LIMIT, 8'hff);
        rd_chk("reading", `OFS_READING, 8'h00);
        rd_chk("csr", `OFS_CSR, 8'h20);
        rd_chk("mask", `OFS_MASK, 8'h06);
        rd_chk("unmapped", 5'h10, 8'h00);
        check("irq", {7'h0, irq}, 8'h00);
        wr(`OFS_LIMIT, 8'h5a);
        rd_chk("limit", `OFS_LIMIT, 8'h5a);
        bus(1'b1, `OFS_LIMIT, 8'h33, 4'h0, v);
        rd_chk("limit", `OFS_LIMIT, 8'h5a);
        wr(`OFS_READING, 8'h77);
        rd_chk("reading", `OFS_READING, 8'h00);
        $display("test reset_access done");

        for (int s = 0; s < 4; s++) begin
            wr(`OFS_CSR, {1'b0, s[1:0], 5'h10});
            enable();
            check("phase", {7'h0, meas_phase}, {7'h0, PH_WAIT});
            tach_u.pulse(4, 64);
            check("phase", {7'h0, meas_phase}, {7'h0, PH_MEAS});
            rd_chk("csr", `OFS_CSR, {1'b0, s[1:0], 5'h10});
            rd_chk("reading", `OFS_READING, 8'h00);
            tach_u.pulse(4, 64);
            rd_chk("csr", `OFS_CSR, {1'b0, s[1:0], 5'h11});
            rd_range("reading", `OFS_READING, (16 >> s) - 1, (16 >> s) + 1);
            rd_chk("csr", `OFS_CSR, {1'b0, s[1:0], 5'h10});
            disable_mon();
        end
        $display("test rates done");

        wr(`OFS_LIMIT, 8'h05);
        wr(`OFS_CSR, 8'h18);
        enable();
        repeat (2) tach_u.pulse(4, 40);
        rd_chk("csr", `OFS_CSR, 8'h1b);
        check("irq", {7'h0, irq}, 8'h01);
        tach_u.pulse(4, 20);
        rd_range("reading", `OFS_READING, 9, 11);
        wr(`OFS_MASK, 8'h04);
        check("irq", {7'h0, irq}, 8'h00);
        wr(`OFS_MASK, 8'h06);
        check("irq", {7'h0, irq}, 8'h01);
        wr(`OFS_CSR, 8'h18);
        rd_chk("csr", `OFS_CSR, 8'h1a);
        wr(`OFS_CSR, 8'h1a);
        check("irq", {7'h0, irq}, 8'h00);
        rd_range("reading", `OFS_READING, 9, 11);
        tach_u.pulse(4, 16);
        rd_chk("csr", `OFS_CSR, 8'h1b);
        disable_mon();
        rd_chk("reading", `OFS_READING, 8'h00);
        $display("test threshold done");

        wr(`OFS_CSR, 8'h1a);
        wr(`OFS_LIMIT, 8'hff);
        enable();
        tach_u.pulse(4, 1100);
        rd_chk("csr", `OFS_CSR, 8'h1c);
        rd_chk("reading", `OFS_READING, 8'h00);
        check("irq", {7'h0, irq}, 8'h01);
        wr(`OFS_CSR, 8'h1c);
        rd_chk("csr", `OFS_CSR, 8'h18);
        check("irq", {7'h0, irq}, 8'h00);
        disable_mon();
        $display("test overflow done");

        wr(`OFS_CSR, 8'h00);
        enable();
        repeat (2) tach_u.pulse(120, 400);
        rd_range("reading", `OFS_READING, 98, 102);
        tach_u.pulse(10, 200);
        tach_u.pulse(120, 400);
        rd_range("reading", `OFS_READING, 148, 155);
        disable_mon();
        $display("test filter done");
        stop_test();
    end

    initial begin
        #3000000;
        miscompares++;
        $display("Error run expected finish seen timeout");
        stop_test();
    end
endmodule
`default_nettype wire
